//--- logic/hvc_pkg.sv
// package: register map, fields and timing constants for the channel controller
package hvc_pkg;
   localparam int unsigned CLK_HZ        = 25_000_000;
   localparam int unsigned VW            = 16;
   localparam int unsigned IW            = 16;
   localparam int unsigned LABEL_CHARS   = 11;
   localparam logic [15:0] TRIP_CONST    = 16'h03E8;
   localparam logic [15:0] TRIP_OFF      = 16'h0000;
   localparam int unsigned TRIP_UNIT_MS  = 100;
   localparam int unsigned TRIP_TICK_CYC = CLK_HZ / 1000 * TRIP_UNIT_MS;
   localparam int unsigned RAMP_TICK_CYC = CLK_HZ;

   localparam logic [11:0] A_ADDR   = 12'h000;
   localparam logic [11:0] A_SWLIM  = 12'h004;
   localparam logic [11:0] A_HWLIM  = 12'h008;
   localparam logic [11:0] A_VSA    = 12'h00C;
   localparam logic [11:0] A_VSB    = 12'h010;
   localparam logic [11:0] A_ILA    = 12'h014;
   localparam logic [11:0] A_ILB    = 12'h018;
   localparam logic [11:0] A_RISE   = 12'h01C;
   localparam logic [11:0] A_FALL   = 12'h020;
   localparam logic [11:0] A_TRIP   = 12'h024;
   localparam logic [11:0] A_CTRL   = 12'h028;
   localparam logic [11:0] A_STAT   = 12'h02C;
   localparam logic [11:0] A_MVLT   = 12'h030;
   localparam logic [11:0] A_MCUR   = 12'h034;
   localparam logic [11:0] A_OUTV   = 12'h038;
   localparam logic [11:0] A_LABEL0 = 12'h040;
   localparam logic [11:0] A_LABEL1 = 12'h044;
   localparam logic [11:0] A_LABEL2 = 12'h048;

   // control register bits
   localparam int unsigned C_ON      = 0;
   localparam int unsigned C_RESTORE = 1;
   localparam int unsigned C_RAMPDN  = 2;
   localparam int unsigned C_CLR     = 3;
   // status register bits
   localparam int unsigned S_ON      = 0;
   localparam int unsigned S_OVCUR   = 1;
   localparam int unsigned S_TRIP    = 2;
   localparam int unsigned S_RAMP    = 3;
   localparam int unsigned S_LBLERR  = 4;

   localparam logic [31:0] ZERO32    = 32'h0000_0000;
   localparam logic [7:0]  CH_ZERO   = 8'h30;
   localparam logic [7:0]  CH_NINE   = 8'h39;
   localparam logic [7:0]  CH_UA     = 8'h41;
   localparam logic [7:0]  CH_UZ     = 8'h5A;
   localparam logic [7:0]  CH_LA     = 8'h61;
   localparam logic [7:0]  CH_LZ     = 8'h7A;
   localparam logic [7:0]  CH_HASH   = 8'h23;
   localparam logic [7:0]  CH_AMP    = 8'h26;
   localparam logic [7:0]  CH_PCT    = 8'h25;
   localparam logic [7:0]  CH_DOL    = 8'h24;
   localparam logic [7:0]  CH_STAR   = 8'h2A;
   localparam logic [7:0]  CH_USC    = 8'h5F;
   localparam logic [7:0]  CH_DASH   = 8'h2D;
   localparam logic [7:0]  CH_NUL    = 8'h00;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } hvc_apb_req_t;

   typedef struct packed {
      logic        prdata_valid;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } hvc_apb_rsp_t;

   typedef struct packed {
      logic [7:0] cluster;
      logic [7:0] slot;
      logic [7:0] chan;
   } hvc_addr_t;

   typedef enum logic {ST_IDLE, ST_ACCESS} hvc_unused_t;
endpackage

//--- logic/hvc_char_check.sv
// leaf: checks one label character against the permitted set
`timescale 1ns/1ps
module hvc_char_check (
   input  wire logic [7:0] ch_i,
   output logic            ok_o
);
   import hvc_pkg::*;
   always_comb begin
      ok_o = (ch_i == CH_NUL)
          || (ch_i >= CH_ZERO && ch_i <= CH_NINE)
          || (ch_i >= CH_UA && ch_i <= CH_UZ)
          || (ch_i >= CH_LA && ch_i <= CH_LZ)
          || (ch_i == CH_HASH) || (ch_i == CH_AMP) || (ch_i == CH_PCT)
          || (ch_i == CH_DOL) || (ch_i == CH_STAR) || (ch_i == CH_USC)
          || (ch_i == CH_DASH);
   end
endmodule

//--- logic/hvc_channel.sv
// top: one high-voltage channel controller with an APB register file
// How it works
// - channel address read-only, writes ignored
// - label up to 11 legal characters
// - voltage select picks setpoint a or b
// - current select picks limit a or b
// - rise no faster than rise rate
// - fall no faster than fall rate
// - off, ramp trip, disable ramp to zero
// - trip value 1000 never switches off
// - programmable protection regulates to current limit
// - fixed protection regulates only at hardware maximum
// - nonzero trip value other than 1000 counts, then switches off
// - reload trip counter on listed events
// - count down only during over-current
// - turn on needs no interlock, enabled
// - turn-on ramps from zero to setpoint
// - switching on clears alarms, reloads counter
// - restore option decides on state at start
// - trip kill cuts, trip ramp falls
// - software limit bounds programmed voltages
// - monitor values readable, not writable
// - hardware limit read-only, writes ignored
// - trip flag set at trip, cleared on on/clear
// - over-current flag when limit reached
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
module hvc_channel #(
   parameter int unsigned TRIP_TICK = hvc_pkg::TRIP_TICK_CYC,
   parameter int unsigned RAMP_TICK = hvc_pkg::RAMP_TICK_CYC,
   parameter bit          PROG_PROT = 1'b1
) (
   input  wire logic                 clk_i,
   input  wire logic                 arst_n_i,
   input  wire hvc_pkg::hvc_apb_req_t apb_req_i,
   output hvc_pkg::hvc_apb_rsp_t     apb_rsp_o,
   input  wire hvc_pkg::hvc_addr_t   chan_addr_i,
   input  wire logic [15:0]          hardware_voltage_limit_i,
   input  wire logic [15:0]          hardware_current_max_i,
   input  wire logic [15:0]          measured_voltage_i,
   input  wire logic [15:0]          measured_current_i,
   input  wire logic                 voltage_select_in_i,
   input  wire logic                 current_select_in_i,
   input  wire logic                 interlock_i,
   input  wire logic                 outputs_enabled_i,
   input  wire logic                 saved_on_i,
   output logic [15:0]               voltage_demand_o,
   output logic [15:0]               current_demand_o,
   output logic                      overcurrent_flag_o,
   output logic                      trip_flag_o,
   output logic                      channel_on_o
);
   import hvc_pkg::*;

   if (TRIP_TICK < 1 || RAMP_TICK < 1) begin : g_bad_tick
      $error("tick counts must be at least one");
   end

   logic [15:0] software_voltage_limit_ff;
   logic [15:0] voltage_setpoint_a_ff;
   logic [15:0] voltage_setpoint_b_ff;
   logic [15:0] current_limit_a_ff;
   logic [15:0] current_limit_b_ff;
   logic [15:0] rise_rate_ff;
   logic [15:0] fall_rate_ff;
   logic [15:0] trip_value_ff;
   logic        channel_on_request_ff;
   logic        restore_at_powerup_ff;
   logic        trip_shutdown_style_ff;
   logic [31:0] label_ff [3];
   logic        label_err_ff;
   logic        on_ff;
   logic        trip_ff;
   logic [15:0] trip_cnt_ff;
   logic [31:0] trip_div_ff;
   logic [31:0] ramp_div_ff;
   logic [15:0] vout_ff;
   logic [31:0] prdata_ff;
   logic        boot_ff;

   logic        wr_acc;
   logic        wr_on;
   logic        wr_trip;
   logic        wr_clr;
   logic        trip_tick;
   logic        ramp_tick;
   logic        overcurrent;
   logic        allowed;
   logic        expire;
   logic        ocf_q;
   logic [15:0] target;
   logic [15:0] setpoint;
   logic [15:0] cur_limit;
   logic [15:0] nxt_vout;
   logic [15:0] limited_wdata;
   logic [3:0]  char_ok;
   logic        label_ok;

   assign wr_acc = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite;
   assign wr_on  = wr_acc && apb_req_i.paddr == A_CTRL && apb_req_i.pwdata[C_ON];
   assign wr_clr = wr_acc && apb_req_i.paddr == A_CTRL && apb_req_i.pwdata[C_CLR];
   assign wr_trip = wr_acc && apb_req_i.paddr == A_TRIP;

   // label character check on the written word
   genvar gi;
   for (gi = 0; gi < 4; gi++) begin : g_chk
      hvc_char_check u_chk (
         .ch_i (apb_req_i.pwdata[8*gi +: 8]),
         .ok_o (char_ok[gi])
      );
   end
   assign label_ok = &char_ok[3:0]
                  && !(apb_req_i.paddr == A_LABEL2 && apb_req_i.pwdata[31:24] != CH_NUL);

   // voltage writes bounded by the software limit
   assign limited_wdata = (apb_req_i.pwdata[15:0] > software_voltage_limit_ff)
                        ? software_voltage_limit_ff : apb_req_i.pwdata[15:0];

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         software_voltage_limit_ff <= 16'hFFFF;
         voltage_setpoint_a_ff     <= 16'h0000;
         voltage_setpoint_b_ff     <= 16'h0000;
         current_limit_a_ff        <= 16'h0000;
         current_limit_b_ff        <= 16'h0000;
         rise_rate_ff              <= 16'h0001;
         fall_rate_ff              <= 16'h0001;
         trip_value_ff             <= TRIP_CONST;
         trip_shutdown_style_ff    <= 1'b0;
      end else if (wr_acc) begin
         unique case (apb_req_i.paddr)
            A_SWLIM: software_voltage_limit_ff <= apb_req_i.pwdata[15:0];
            A_VSA:   voltage_setpoint_a_ff <= limited_wdata;
            A_VSB:   voltage_setpoint_b_ff <= limited_wdata;
            A_ILA:   current_limit_a_ff <= apb_req_i.pwdata[15:0];
            A_ILB:   current_limit_b_ff <= apb_req_i.pwdata[15:0];
            A_RISE:  rise_rate_ff <= apb_req_i.pwdata[15:0];
            A_FALL:  fall_rate_ff <= apb_req_i.pwdata[15:0];
            A_TRIP:  trip_value_ff <= apb_req_i.pwdata[15:0];
            A_CTRL: begin
               trip_shutdown_style_ff <= apb_req_i.pwdata[C_RAMPDN];
            end
            default: ; // address, limit, monitors: read-only
         endcase
      end
   end

   // restore option survives a warm reset, so no reset branch
   always_ff @(posedge clk_i) begin
      if (wr_acc && apb_req_i.paddr == A_CTRL) begin
         restore_at_powerup_ff <= apb_req_i.pwdata[C_RESTORE];
      end
   end

   // label storage, rejected words flag an error
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         label_ff[0]  <= ZERO32;
         label_ff[1]  <= ZERO32;
         label_ff[2]  <= ZERO32;
         label_err_ff <= 1'b0;
      end else if (wr_acc && (apb_req_i.paddr == A_LABEL0 || apb_req_i.paddr == A_LABEL1
                              || apb_req_i.paddr == A_LABEL2)) begin
         if (label_ok) begin
            label_ff[apb_req_i.paddr[3:2]] <= apb_req_i.pwdata;
            label_err_ff <= 1'b0;
         end else begin
            label_err_ff <= 1'b1;
         end
      end
   end

   // on request: software writes and start-up restore
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         boot_ff               <= 1'b1;
         channel_on_request_ff <= 1'b0;
      end else begin
         boot_ff <= 1'b0;
         if (boot_ff) begin
            channel_on_request_ff <= restore_at_powerup_ff & saved_on_i;
         end else if (wr_acc && apb_req_i.paddr == A_CTRL) begin
            channel_on_request_ff <= apb_req_i.pwdata[C_ON];
         end
      end
   end

   assign allowed = !interlock_i && outputs_enabled_i;

   // selection of setpoint and limit
   assign setpoint  = voltage_select_in_i ? voltage_setpoint_b_ff : voltage_setpoint_a_ff;
   assign cur_limit = current_select_in_i ? current_limit_b_ff : current_limit_a_ff;
   assign overcurrent = measured_current_i >= cur_limit;

   // tick dividers
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         trip_div_ff <= ZERO32;
         ramp_div_ff <= ZERO32;
      end else begin
         trip_div_ff <= trip_tick ? ZERO32 : trip_div_ff + 32'h1;
         ramp_div_ff <= ramp_tick ? ZERO32 : ramp_div_ff + 32'h1;
      end
   end
   assign trip_tick = trip_div_ff == 32'(TRIP_TICK - 1);
   assign ramp_tick = ramp_div_ff == 32'(RAMP_TICK - 1);

   // trip counter
   assign expire = on_ff && overcurrent && trip_tick && trip_value_ff != TRIP_CONST
                && trip_value_ff != TRIP_OFF && trip_cnt_ff == 16'h0001;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         trip_cnt_ff <= TRIP_CONST;
      end else if (wr_trip) begin
         trip_cnt_ff <= apb_req_i.pwdata[15:0];
      end else if (wr_clr || wr_on || !overcurrent) begin
         trip_cnt_ff <= trip_value_ff;
      end else if (on_ff && trip_tick && trip_cnt_ff != 16'h0000
                   && trip_value_ff != TRIP_CONST) begin
         trip_cnt_ff <= trip_cnt_ff - 16'h0001;
      end
   end

   // channel on state and trip flag
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         on_ff   <= 1'b0;
         trip_ff <= 1'b0;
      end else begin
         if (expire) begin
            on_ff   <= 1'b0;
            trip_ff <= 1'b1;
         end else begin
            if (!channel_on_request_ff || !allowed) begin
               on_ff <= 1'b0;
            end else if (wr_on || (boot_ff == 1'b0 && !on_ff && !trip_ff)) begin
               on_ff <= 1'b1;
            end
            if (wr_on || wr_clr) begin
               trip_ff <= 1'b0;
            end
         end
      end
   end

   // ramp generator
   assign target = !on_ff ? 16'h0000
                 : (setpoint > software_voltage_limit_ff ? software_voltage_limit_ff
                    : setpoint);
   always_comb begin
      nxt_vout = vout_ff;
      if (expire && !trip_shutdown_style_ff) begin
         nxt_vout = 16'h0000;
      end else if (ramp_tick && vout_ff < target) begin
         nxt_vout = (target - vout_ff > rise_rate_ff) ? vout_ff + rise_rate_ff : target;
      end else if (ramp_tick && vout_ff > target) begin
         nxt_vout = (vout_ff - target > fall_rate_ff) ? vout_ff - fall_rate_ff : target;
      end
   end
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         vout_ff <= 16'h0000;
      end else begin
         vout_ff <= nxt_vout;
      end
   end

   // demand outputs to the analog stage
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         voltage_demand_o   <= 16'h0000;
         current_demand_o   <= 16'h0000;
         overcurrent_flag_o <= 1'b0;
      end else begin
         voltage_demand_o   <= (vout_ff > hardware_voltage_limit_i)
                             ? hardware_voltage_limit_i : vout_ff;
         current_demand_o   <= PROG_PROT ? cur_limit : hardware_current_max_i;
         overcurrent_flag_o <= overcurrent;
      end
   end
   assign trip_flag_o  = trip_ff;
   assign channel_on_o = on_ff;

   // read data
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prdata_ff <= ZERO32;
      end else if (apb_req_i.psel && !apb_req_i.penable && !apb_req_i.pwrite) begin
         unique case (apb_req_i.paddr)
            A_ADDR:   prdata_ff <= {8'h00, chan_addr_i};
            A_SWLIM:  prdata_ff <= {16'h0000, software_voltage_limit_ff};
            A_HWLIM:  prdata_ff <= {16'h0000, hardware_voltage_limit_i};
            A_VSA:    prdata_ff <= {16'h0000, voltage_setpoint_a_ff};
            A_VSB:    prdata_ff <= {16'h0000, voltage_setpoint_b_ff};
            A_ILA:    prdata_ff <= {16'h0000, current_limit_a_ff};
            A_ILB:    prdata_ff <= {16'h0000, current_limit_b_ff};
            A_RISE:   prdata_ff <= {16'h0000, rise_rate_ff};
            A_FALL:   prdata_ff <= {16'h0000, fall_rate_ff};
            A_TRIP:   prdata_ff <= {trip_cnt_ff, trip_value_ff};
            A_CTRL:   prdata_ff <= {28'h0000000, 1'b0, trip_shutdown_style_ff,
                                    restore_at_powerup_ff, channel_on_request_ff};
            A_STAT:   prdata_ff <= {27'h0000000, label_err_ff, vout_ff != target,
                                    trip_ff, overcurrent, on_ff};
            A_MVLT:   prdata_ff <= {16'h0000, measured_voltage_i};
            A_MCUR:   prdata_ff <= {16'h0000, measured_current_i};
            A_OUTV:   prdata_ff <= {16'h0000, vout_ff};
            A_LABEL0: prdata_ff <= label_ff[0];
            A_LABEL1: prdata_ff <= label_ff[1];
            A_LABEL2: prdata_ff <= label_ff[2];
            default:  prdata_ff <= ZERO32;
         endcase
      end
   end
   assign apb_rsp_o.prdata       = prdata_ff;
   assign apb_rsp_o.pready       = 1'b1;
   assign apb_rsp_o.pslverr      = 1'b0;
   assign apb_rsp_o.prdata_valid = apb_req_i.psel & apb_req_i.penable & ~apb_req_i.pwrite;

   assign ocf_q = overcurrent_flag_o;

   AST_TRIP_OFF: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      expire |=> !on_ff && trip_ff)
      else $error("trip did not switch channel off");
   AST_CONST_MODE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      trip_value_ff == TRIP_CONST && on_ff && overcurrent && channel_on_request_ff && allowed
      |=> on_ff && !trip_ff)
      else $error("constant current mode tripped");
   AST_RISE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (vout_ff > $past(vout_ff)) |-> (vout_ff - $past(vout_ff) <= $past(rise_rate_ff)))
      else $error("rise faster than rate");
   AST_FALL: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (vout_ff < $past(vout_ff) && !$past(expire))
      |-> ($past(vout_ff) - vout_ff <= $past(fall_rate_ff)))
      else $error("fall faster than rate");
   AST_KILL: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      expire && !trip_shutdown_style_ff |=> vout_ff == 16'h0000)
      else $error("kill did not cut output");
   AST_INTERLOCK: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !allowed |=> !on_ff)
      else $error("channel on while blocked");
   AST_RELOAD: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (!overcurrent && !wr_trip) |=> trip_cnt_ff == $past(trip_value_ff))
      else $error("trip counter not reloaded");
   AST_OVERCUR: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      overcurrent |=> ocf_q)
      else $error("overcurrent flag missing");
   AST_CLAMP: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      target <= software_voltage_limit_ff)
      else $error("target above software limit");
endmodule

//--- dv/hvc_hv_stage.sv
// partner model: analog output stage feeding back voltage and current monitors
`timescale 1ns/1ps
module hvc_hv_stage (
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   input  wire logic [15:0] voltage_demand_i,
   input  wire logic [15:0] current_demand_i,
   input  wire logic        overload_i,
   output logic      [15:0] measured_voltage_o,
   output logic      [15:0] measured_current_o
);
   // normal load draws a quarter of the limit, overload pins it at the limit
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         measured_voltage_o <= 16'h0000;
         measured_current_o <= 16'h0000;
      end else begin
         measured_voltage_o <= voltage_demand_i;
         measured_current_o <= overload_i ? current_demand_i : (current_demand_i >> 2);
      end
   end
endmodule

//--- dv/hvc_channel_tb_top.sv
// testbench: apb register tests and output ramp and trip scenarios
`timescale 1ns/1ps
module hvc_channel_tb_top;
   import hvc_pkg::*;
   localparam int unsigned RT = 4;
   localparam int unsigned TT = 3;
   logic         clk_i    = 1'b0;
   logic         arst_n_i = 1'b0;
   hvc_apb_req_t req      = '0;
   hvc_apb_rsp_t rsp;
   hvc_addr_t    ca       = 24'h010503;
   logic         voltage_select_in = 1'b0, csel = 1'b0, ilk = 1'b0, en = 1'b1, saved = 1'b0, ovl = 1'b0;
   logic [15:0]  mv, mi, vd, id;
   logic         ovcf, trip, on;
   logic [31:0]  rdat;
   logic         rate_en = 1'b0;
   logic [15:0]  vp = 16'h0000;
   logic [15:0]  hwl = 16'h0FA0;
   int           n_errors = 0;
   int           n_checks = 0;

   always #20 clk_i = ~clk_i;

   hvc_channel #(.TRIP_TICK(TT), .RAMP_TICK(RT), .PROG_PROT(1'b1)) u_dut (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .apb_req_i(req), .apb_rsp_o(rsp),
      .chan_addr_i(ca), .hardware_voltage_limit_i(hwl),
      .hardware_current_max_i(16'h0200), .measured_voltage_i(mv),
      .measured_current_i(mi), .voltage_select_in_i(voltage_select_in), .current_select_in_i(csel),
      .interlock_i(ilk), .outputs_enabled_i(en), .saved_on_i(saved),
      .voltage_demand_o(vd), .current_demand_o(id), .overcurrent_flag_o(ovcf),
      .trip_flag_o(trip), .channel_on_o(on));

   hvc_hv_stage u_stage (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .voltage_demand_i(vd), .current_demand_i(id),
      .overload_i(ovl), .measured_voltage_o(mv), .measured_current_o(mi));

   task automatic tally_and_finish;
      $display("errors %0d checks %0d", n_errors, n_checks);
      if (n_errors == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one apb transfer; read data taken at the edge where pready is seen
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clk_i);
      req.penable <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (rsp.pready !== 1'b1 && n < 50);
      rdat = rsp.prdata;
      chk("pslverr", 32'h0, 32'(rsp.pslverr));
      if (!w) chk("prdata valid", 32'h1, 32'(rsp.prdata_valid));
      req <= '0;
      if (n >= 50) begin
         chk("pready", 32'h1, 32'(rsp.pready));
         tally_and_finish();
      end
   endtask

   function automatic logic [15:0] pick(input int w);
      case (w)
         0: return vd;
         1: return {15'h0000, trip};
         default: return {15'h0000, ovcf};
      endcase
   endfunction

   // bounded wait for an output to reach a value
   task automatic wait_for(input int w, input logic [15:0] v);
      int n;
      n = 0;
      while (pick(w) !== v && n < 2000) begin
         @(negedge clk_i);
         n++;
      end
      chk("wait target", 32'(v), 32'(pick(w)));
      if (n >= 2000) tally_and_finish();
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   // per-cycle slope monitor against rise 10 and fall 7
   always @(negedge clk_i) begin
      if (rate_en && arst_n_i && vd > vp && vd - vp > 16'h000A) begin
         n_errors++;
         $display("wrong value rise step expected 000a seen %h", vd - vp);
      end
      if (rate_en && arst_n_i && vd < vp && vp - vd > 16'h0007) begin
         n_errors++;
         $display("wrong value fall step expected 0007 seen %h", vp - vd);
      end
      vp = vd;
   end

   initial begin
      repeat (5) @(posedge clk_i);
      arst_n_i <= 1'b1;
      xfer(0, A_ADDR, 0);
      chk("chan addr", 32'h0001_0503, rdat);
      xfer(1, A_ADDR, 32'hFFFF_FFFF);
      xfer(0, A_ADDR, 0);
      chk("chan addr ro", 32'h0001_0503, rdat);
      xfer(1, A_HWLIM, 0);
      xfer(0, A_HWLIM, 0);
      chk("hw limit ro", 32'h0000_0FA0, rdat);
      xfer(0, A_SWLIM, 0);
      chk("sw limit", 32'h0000_FFFF, rdat);
      xfer(0, A_TRIP, 0);
      chk("trip value", 32'h0000_03E8, rdat & 32'h0000_FFFF);
      xfer(1, A_LABEL0, 32'h3123_6241);
      xfer(0, A_STAT, 0);
      chk("label err", 32'h0, 32'(rdat[S_LBLERR]));
      xfer(1, A_LABEL1, 32'h2041_4141);
      xfer(0, A_STAT, 0);
      chk("label err", 32'h1, 32'(rdat[S_LBLERR]));
      xfer(1, A_LABEL2, 32'h002D_5F2A);
      xfer(0, A_STAT, 0);
      chk("label err", 32'h0, 32'(rdat[S_LBLERR]));
      xfer(0, A_LABEL0, 0);
      chk("label word", 32'h3123_6241, rdat);
      xfer(0, A_LABEL1, 0);
      chk("label refused", 32'h0, rdat);
      xfer(1, A_VSA, 32'd100);
      xfer(1, A_VSB, 32'd200);
      xfer(1, A_ILA, 32'd50);
      xfer(1, A_ILB, 32'd60);
      xfer(1, A_RISE, 32'd10);
      xfer(1, A_FALL, 32'd7);
      cyc(2);
      chk("current demand a", 32'd50, 32'(id));
      @(posedge clk_i) csel <= 1'b1;
      cyc(3);
      chk("current demand b", 32'd60, 32'(id));
      @(posedge clk_i) begin csel <= 1'b0; ilk <= 1'b1; end
      xfer(1, A_CTRL, 32'h1);
      cyc(20);
      chk("on blocked", 32'h0, 32'(on));
      chk("demand blocked", 32'h0, 32'(vd));
      rate_en = 1'b1;
      @(posedge clk_i) ilk <= 1'b0;
      xfer(1, A_CTRL, 32'h1);
      wait_for(0, 16'd100);
      chk("on", 32'h1, 32'(on));
      cyc(3);
      xfer(1, A_MVLT, 0);
      xfer(0, A_MVLT, 0);
      chk("meas volt", 32'd100, rdat);
      xfer(0, A_MCUR, 0);
      chk("meas cur", 32'd12, rdat);
      xfer(1, A_SWLIM, 32'd150);
      @(posedge clk_i) voltage_select_in <= 1'b1;
      wait_for(0, 16'd150);
      cyc(40);
      chk("clamped", 32'd150, 32'(vd));
      rate_en = 1'b0;
      @(posedge clk_i) hwl <= 16'h0078;
      cyc(2);
      chk("hw clamp", 32'd120, 32'(vd));
      @(posedge clk_i) hwl <= 16'h0FA0;
      cyc(3);
      rate_en = 1'b1;
      @(posedge clk_i) voltage_select_in <= 1'b0;
      wait_for(0, 16'd100);
      @(posedge clk_i) en <= 1'b0;
      wait_for(0, 16'd0);
      @(posedge clk_i) en <= 1'b1;
      wait_for(0, 16'd100);
      xfer(1, A_CTRL, 32'h0);
      wait_for(0, 16'd0);
      xfer(1, A_TRIP, 32'd2);
      xfer(1, A_CTRL, 32'h1);
      wait_for(0, 16'd100);
      rate_en = 1'b0;
      @(posedge clk_i) ovl <= 1'b1;
      wait_for(2, 16'd1);
      cyc(2);
      chk("early trip", 32'h0, 32'(trip));
      wait_for(1, 16'd1);
      cyc(3);
      chk("kill", 32'h0, 32'(vd));
      chk("off", 32'h0, 32'(on));
      @(posedge clk_i) ovl <= 1'b0;
      xfer(1, A_CTRL, 32'h5);
      cyc(1);
      chk("trip cleared", 32'h0, 32'(trip));
      rate_en = 1'b1;
      wait_for(0, 16'd100);
      @(posedge clk_i) ovl <= 1'b1;
      wait_for(1, 16'd1);
      wait_for(0, 16'd0);
      @(posedge clk_i) ovl <= 1'b0;
      xfer(1, A_CTRL, 32'h8);
      cyc(2);
      chk("alarm clear", 32'h0, 32'(trip));
      xfer(1, A_TRIP, 32'd1000);
      xfer(1, A_CTRL, 32'h1);
      wait_for(0, 16'd100);
      @(posedge clk_i) ovl <= 1'b1;
      cyc(20 * TT);
      chk("const current trip", 32'h0, 32'(trip));
      chk("const current on", 32'h1, 32'(on));
      rate_en = 1'b0;
      @(posedge clk_i) begin ovl <= 1'b0; saved <= 1'b1; arst_n_i <= 1'b0; end
      repeat (5) @(posedge clk_i);
      arst_n_i <= 1'b1;
      cyc(10);
      chk("restore off", 32'h0, 32'(on));
      chk("restore demand", 32'h0, 32'(vd));
      xfer(1, A_CTRL, 32'h3);
      @(posedge clk_i) arst_n_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      arst_n_i <= 1'b1;
      cyc(10);
      chk("restore on", 32'h1, 32'(on));
      tally_and_finish();
   end
endmodule
